// file: include/aip_pkg.sv
`default_nettype none
package aip_pkg;
	// Register decode addresses on the processor's external-data space.
	localparam logic [15:0] ADDR_PTR_LOW = 16'h7FE4;
	localparam logic [15:0] ADDR_DATA_PORT = 16'h7FE5;
	localparam logic [15:0] ADDR_PTR_HIGH = 16'h7FE3;
	localparam logic [15:0] ADDR_FAST_CTRL = 16'h7FE2;
	// Fast transfer control fields.
	localparam int FAST_BULK_BIT = 6;
	localparam int READ_POL_BIT = 2;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	// Values after reset.
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] FAST_CTRL_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	// Default window of internal program/data RAM reachable by the pointer.
	localparam logic [15:0] RAM_BASE_DEFAULT = 16'h0000;
	localparam logic [16:0] RAM_SIZE_DEFAULT = 17'h02000;
	// Fast transfer must finish within this time; the clock runs at 40 ns.
	localparam int FAST_XFER_NS = 333;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FAST_XFER_CYCLES = FAST_XFER_NS / CLK_PERIOD_NS;
	// Write buffer between the processor and the RAM.
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 24;
	// Request sequencer states.
	typedef enum logic [1:0] {
		AIP_IDLE,
		AIP_PUSH,
		AIP_DRAIN,
		AIP_READ
	} aip_state_t;
endpackage
`default_nettype wire

// file: include/aip_fifo_if.sv
`default_nettype none
interface aip_fifo_if #(
	parameter int WIDTH = 24
);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	logic empty;

	// Buffer side.
	modport buffer (
		input in_valid,
		output in_ready,
		input in_data,
		output out_valid,
		input out_ready,
		output out_data,
		output empty
	);
	// User side, both filling and draining.
	modport user (
		output in_valid,
		input in_ready,
		output in_data,
		input out_valid,
		output out_ready,
		input out_data,
		input empty
	);
endinterface
`default_nettype wire

// file: verilog/aip_fifo.sv
`default_nettype none
module aip_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Filling and draining handshakes.
	aip_fifo_if.buffer fifo
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	// Full and empty follow the occupancy count, so ready never lies.
	assign fifo.in_ready = (count_ff != (AW+1)'(DEPTH));
	assign fifo.out_valid = (count_ff != '0);
	assign fifo.empty = (count_ff == '0);
	assign fifo.out_data = mem_ff[rd_ptr_ff];
	assign push = fifo.in_valid && fifo.in_ready;
	assign pop = fifo.out_valid && fifo.out_ready;

	// Storage is written only on an accepted push.
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= fifo.in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/aip_top.sv
// Summary of operation
// RQ1: A 16-bit RAM address is held in a high byte and a low byte register.
// RQ2: Each data port access uses the pointer address, then the pointer advances by one.
// RQ3: Pointer bytes are readable and writable anytime; reads show the next access address. Here an access is taken only while cpu_busy_o is low.
// RQ4: Pointer low byte decodes at 7FE4 and the data port at 7FE5, eight bits each.
// RQ5: Pointer accesses reach only internal program/data RAM, nothing outside that window.
// RQ6: Fast bulk needs the enable bit, an access to the data port, and a data move.
// RQ7: Fast mode moves each byte between buffer and external bus within 333 ns, eight cycles.
// RQ8: Processor enables fast bulk with bit 6 set, polarity and mode bits clear.
// RQ9: Processor loads the pointer first, then streams through the data port.
// RQ10: The pointer increment carries from the low byte into the high byte.
`default_nettype none
module aip_top #(
	parameter logic [15:0] RAM_BASE = aip_pkg::RAM_BASE_DEFAULT,
	parameter logic [16:0] RAM_SIZE = aip_pkg::RAM_SIZE_DEFAULT,
	parameter int FIFO_DEPTH = aip_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Processor external-data access.
	input wire logic cpu_req_i,
	input wire logic cpu_we_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic cpu_busy_o,
	output logic cpu_ack_o,
	output logic [7:0] cpu_rdata_o,
	// Internal RAM port.
	output logic [15:0] ram_addr_o,
	output logic [7:0] ram_wdata_o,
	output logic ram_we_o,
	output logic ram_re_o,
	input wire logic ram_ready_i,
	input wire logic [7:0] ram_rdata_i,
	// External bus for fast transfers.
	input wire logic [7:0] ext_data_i,
	output logic [7:0] ext_data_o,
	output logic ext_strobe_o,
	output logic fast_bulk_enable_o
);
	localparam int W = aip_pkg::FIFO_WIDTH;

	aip_pkg::aip_state_t state_ff;
	logic [7:0] pointer_high_byte_ff;
	logic [7:0] pointer_low_byte_ff;
	logic [7:0] fast_transfer_control_ff;
	logic busy_ff;
	logic ack_ff;
	logic [7:0] rdata_ff;
	logic [15:0] ram_addr_ff;
	logic [7:0] ram_wdata_ff;
	logic ram_we_ff;
	logic ram_re_ff;
	logic [7:0] ext_data_ff;
	logic ext_strobe_ff;
	logic [7:0] wr_byte_ff;
	logic [15:0] req_ptr_ff;
	logic req_fast_ff;
	logic [15:0] pointer;
	logic [15:0] nxt_pointer;
	logic take;
	logic take_data;
	logic in_window;
	logic fast_bulk;
	logic pop;
	logic [16:0] ptr_offset;

	aip_fifo_if #(.WIDTH(W)) wbuf ();

	aip_fifo #(
		.WIDTH(W),
		.DEPTH(FIFO_DEPTH)
	) u_wbuf (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.fifo(wbuf)
	);

	// The two pointer bytes form one address; the increment is a full word add.
	assign pointer = {pointer_high_byte_ff, pointer_low_byte_ff}; // RQ1
	assign nxt_pointer = pointer + 16'h0001; // RQ10
	assign fast_bulk = fast_transfer_control_ff[aip_pkg::FAST_BULK_BIT];
	assign take = cpu_req_i && !busy_ff;
	assign take_data = take && (cpu_addr_i == aip_pkg::ADDR_DATA_PORT); // RQ4
	// Window check on the latched address keeps the RAM strobes off anything outside.
	assign ptr_offset = {1'b0, req_ptr_ff} - {1'b0, RAM_BASE};
	assign in_window = (req_ptr_ff >= RAM_BASE) && (ptr_offset < RAM_SIZE); // RQ5

	// Write buffer filling from the sequencer, draining into the RAM stage.
	// A byte outside the window is acked but never queued, so it cannot reach the RAM.
	assign wbuf.in_valid = (state_ff == aip_pkg::AIP_PUSH) && in_window; // RQ5
	assign wbuf.in_data = {req_ptr_ff, wr_byte_ff};
	assign pop = wbuf.out_valid && (!ram_we_ff || ram_ready_i) && !ram_re_ff;
	assign wbuf.out_ready = pop;

	// Pointer registers; a data port access moves the pointer on the take edge.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pointer_high_byte_ff <= aip_pkg::PTR_RESET;
			pointer_low_byte_ff <= aip_pkg::PTR_RESET;
		end else if (take && cpu_we_i && cpu_addr_i == aip_pkg::ADDR_PTR_HIGH) begin
			pointer_high_byte_ff <= cpu_wdata_i; // RQ3
		end else if (take && cpu_we_i && cpu_addr_i == aip_pkg::ADDR_PTR_LOW) begin
			pointer_low_byte_ff <= cpu_wdata_i; // RQ3
		end else if (take_data) begin
			pointer_high_byte_ff <= nxt_pointer[15:8]; // RQ2
			pointer_low_byte_ff <= nxt_pointer[7:0]; // RQ2
		end
	end

	// Fast transfer control; only the enable bit steers logic here.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fast_transfer_control_ff <= aip_pkg::FAST_CTRL_RESET;
		end else if (take && cpu_we_i && cpu_addr_i == aip_pkg::ADDR_FAST_CTRL) begin
			fast_transfer_control_ff <= cpu_wdata_i;
		end
	end

	// Latch the access address and byte so the pointer may move on at once.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_ptr_ff <= 16'h0000;
			wr_byte_ff <= 8'h00;
			req_fast_ff <= 1'b0;
		end else if (take_data) begin
			req_ptr_ff <= pointer; // RQ2
			// In fast mode a write takes its byte from the external bus.
			wr_byte_ff <= fast_bulk ? ext_data_i : cpu_wdata_i; // RQ6
			req_fast_ff <= fast_bulk; // RQ6
		end
	end

	// Sequencer for data port accesses; register accesses finish in one cycle.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= aip_pkg::AIP_IDLE;
		end else begin
			case (state_ff)
				aip_pkg::AIP_IDLE: begin
					if (take_data) begin
						state_ff <= cpu_we_i ? aip_pkg::AIP_PUSH : aip_pkg::AIP_DRAIN;
					end
				end
				aip_pkg::AIP_PUSH: begin
					if (wbuf.in_ready || !in_window) begin
						state_ff <= aip_pkg::AIP_IDLE;
					end
				end
				aip_pkg::AIP_DRAIN: begin
					// Reads wait for earlier writes so they never see stale bytes.
					if (wbuf.empty && !ram_we_ff) begin
						state_ff <= aip_pkg::AIP_READ;
					end
				end
				aip_pkg::AIP_READ: begin
					if (!ram_re_ff) begin
						state_ff <= aip_pkg::AIP_IDLE;
					end
				end
				default: begin
					state_ff <= aip_pkg::AIP_IDLE;
				end
			endcase
		end
	end

	// RAM port stage; it holds a write until the RAM signals ready.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ram_addr_ff <= 16'h0000;
			ram_wdata_ff <= 8'h00;
			ram_we_ff <= 1'b0;
			ram_re_ff <= 1'b0;
		end else if (pop) begin
			ram_addr_ff <= wbuf.out_data[W-1:8];
			ram_wdata_ff <= wbuf.out_data[7:0];
			ram_we_ff <= 1'b1;
		end else if (ram_we_ff && ram_ready_i) begin
			ram_we_ff <= 1'b0;
		end else if (state_ff == aip_pkg::AIP_DRAIN && wbuf.empty && !ram_we_ff) begin
			ram_addr_ff <= req_ptr_ff;
			ram_re_ff <= in_window; // RQ5
		end else begin
			ram_re_ff <= 1'b0;
		end
	end

	// Answer to the processor, and the byte register read path.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= aip_pkg::RDATA_RESET;
		end else begin
			ack_ff <= 1'b0;
			if (take && !take_data) begin
				ack_ff <= 1'b1;
				case (cpu_addr_i)
					aip_pkg::ADDR_PTR_HIGH: rdata_ff <= pointer_high_byte_ff; // RQ3
					aip_pkg::ADDR_PTR_LOW: rdata_ff <= pointer_low_byte_ff; // RQ3
					aip_pkg::ADDR_FAST_CTRL: rdata_ff <= fast_transfer_control_ff;
					default: rdata_ff <= aip_pkg::RDATA_RESET;
				endcase
			end else if (take_data) begin
				busy_ff <= 1'b1;
			end else if (state_ff == aip_pkg::AIP_PUSH && (wbuf.in_ready || !in_window)) begin
				// A full buffer holds the processor off until a slot frees.
				busy_ff <= 1'b0;
				ack_ff <= 1'b1;
			end else if (state_ff == aip_pkg::AIP_READ && !ram_re_ff) begin
				// Bytes outside the RAM window read as zero.
				rdata_ff <= in_window ? ram_rdata_i : aip_pkg::RDATA_RESET; // RQ5
				busy_ff <= 1'b0;
				ack_ff <= 1'b1;
			end
		end
	end

	// Fast mode: a read byte is handed to the external bus with the answer; a write only pulses the strobe.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_data_ff <= 8'h00;
			ext_strobe_ff <= 1'b0;
		end else begin
			ext_strobe_ff <= 1'b0;
			if (req_fast_ff && state_ff == aip_pkg::AIP_READ && !ram_re_ff) begin
				ext_data_ff <= in_window ? ram_rdata_i : aip_pkg::RDATA_RESET; // RQ7
				ext_strobe_ff <= 1'b1; // RQ7
			end else if (req_fast_ff && state_ff == aip_pkg::AIP_PUSH && wbuf.in_ready) begin
				ext_strobe_ff <= 1'b1; // RQ7
			end
		end
	end

	assign cpu_busy_o = busy_ff;
	assign cpu_ack_o = ack_ff;
	assign cpu_rdata_o = rdata_ff;
	assign ram_addr_o = ram_addr_ff;
	assign ram_wdata_o = ram_wdata_ff;
	assign ram_we_o = ram_we_ff;
	assign ram_re_o = ram_re_ff;
	assign ext_data_o = ext_data_ff;
	assign ext_strobe_o = ext_strobe_ff;
	assign fast_bulk_enable_o = fast_transfer_control_ff[aip_pkg::FAST_BULK_BIT];
endmodule
`default_nettype wire

// file: tb/aip_top_monitor.sv
`default_nettype none
module aip_top_monitor #(
	parameter logic [15:0] RAM_BASE = 16'h0000,
	parameter logic [16:0] RAM_SIZE = 17'h02000
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Processor side.
	input wire logic cpu_req_i,
	input wire logic cpu_we_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [7:0] cpu_wdata_i,
	input wire logic cpu_busy_o,
	input wire logic cpu_ack_o,
	// RAM and external side.
	input wire logic [15:0] ram_addr_o,
	input wire logic [7:0] ram_wdata_o,
	input wire logic ram_we_o,
	input wire logic ram_re_o,
	input wire logic ram_ready_i,
	input wire logic ext_strobe_o,
	input wire logic fast_bulk_enable_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// A request counts only while the sequencer is idle.
	logic take;
	assign take = cpu_req_i & ~cpu_busy_o;
	sequence data_take;
		take && cpu_addr_i == 16'h7FE5;
	endsequence
	sequence fast_write;
		data_take and (cpu_we_i && fast_bulk_enable_o);
	endsequence
	chk_reg_ack: assert property (take && cpu_addr_i != 16'h7FE5 |=> cpu_ack_o && !cpu_busy_o)
		else $error("register access not acked next cycle");
	chk_data_busy: assert property (data_take |=> cpu_busy_o)
		else $error("data port take did not raise busy");
	chk_ack_cause: assert property (cpu_ack_o |-> $past(take) || $past(cpu_busy_o))
		else $error("ack without a request");
	chk_re_pulse: assert property (ram_re_o |=> !ram_re_o)
		else $error("RAM read strobe longer than one cycle");
	chk_we_hold: assert property (ram_we_o && !ram_ready_i |=>
		ram_we_o && $stable(ram_addr_o) && $stable(ram_wdata_o))
		else $error("RAM write dropped before ready");
	chk_ram_window: assert property (ram_we_o || ram_re_o |->
		ram_addr_o >= RAM_BASE && {1'b0, ram_addr_o} < RAM_BASE + RAM_SIZE)
		else $error("RAM access outside internal window");
	chk_fast_flag: assert property (take && cpu_we_i && cpu_addr_i == 16'h7FE2 |=>
		fast_bulk_enable_o == $past(cpu_wdata_i[6]))
		else $error("fast enable does not follow bit 6");
	chk_strobe_gate: assert property (ext_strobe_o |-> fast_bulk_enable_o && cpu_ack_o)
		else $error("external strobe outside fast mode");
	chk_fast_time: assert property (fast_write |-> ##[1:8] ext_strobe_o)
		else $error("fast byte not moved in time");
endmodule
`default_nettype wire

// file: tb/aip_ram_model.sv
`default_nettype none
module aip_ram_model (
	// Clock and stall control.
	input wire logic sys_clk_i,
	input wire logic stall_i,
	// RAM port.
	input wire logic ram_we_i,
	input wire logic ram_re_i,
	input wire logic [15:0] ram_addr_i,
	input wire logic [7:0] ram_wdata_i,
	output logic ram_ready_o,
	output logic [7:0] ram_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:511];
	// A stalled RAM holds off writes so the buffer fills up.
	assign ram_ready_o = ram_we_i & ~stall_i;
	initial ram_rdata_o = 8'hC3;
	// Read data stands one cycle; otherwise it toggles so stale bytes never match.
	always @(posedge sys_clk_i) begin
		if (ram_we_i && !stall_i) mem[ram_addr_i[8:0]] <= ram_wdata_i;
		ram_rdata_o <= ram_re_i ? mem[ram_addr_i[8:0]] : ~ram_rdata_o;
	end
endmodule
`default_nettype wire

// file: tb/aip_top_tb.sv
`default_nettype none
module aip_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic w;
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} aip_row_t;
	logic sys_clk, reset_n, cpu_req, cpu_we, cpu_busy, cpu_ack, ram_we, ram_re, ram_ready;
	logic ext_strobe, fbe, stall, ok;
	logic [15:0] cpu_addr, ram_addr;
	logic [7:0] cpu_wdata, cpu_rdata, ram_wdata, ram_rdata, ext_in, ext_out, rd, xb;
	int num_errors = 0, samples_checked = 0, cyc = 0, n;
	// Register rows: write or read, address, data, expected read byte.
	aip_row_t rows [8] = '{'{1'b1, 16'h7FE3, 8'h12, 8'h00}, '{1'b1, 16'h7FE4, 8'h34, 8'h00},
		'{1'b1, 16'h7F00, 8'hFF, 8'h00}, '{1'b0, 16'h7FE3, 8'h00, 8'h12},
		'{1'b0, 16'h7FE4, 8'h00, 8'h34}, '{1'b1, 16'h7FE2, 8'h05, 8'h00},
		'{1'b0, 16'h7FE2, 8'h00, 8'h05}, '{1'b0, 16'h7F00, 8'h00, 8'h00}};
	aip_top aip_top_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .cpu_req_i(cpu_req),
		.cpu_we_i(cpu_we), .cpu_addr_i(cpu_addr), .cpu_wdata_i(cpu_wdata), .cpu_busy_o(cpu_busy),
		.cpu_ack_o(cpu_ack), .cpu_rdata_o(cpu_rdata), .ram_addr_o(ram_addr),
		.ram_wdata_o(ram_wdata), .ram_we_o(ram_we), .ram_re_o(ram_re), .ram_ready_i(ram_ready),
		.ram_rdata_i(ram_rdata), .ext_data_i(ext_in), .ext_data_o(ext_out),
		.ext_strobe_o(ext_strobe), .fast_bulk_enable_o(fbe));
	aip_ram_model aip_ram_model_inst (.sys_clk_i(sys_clk), .stall_i(stall), .ram_we_i(ram_we),
		.ram_re_i(ram_re), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wdata),
		.ram_ready_o(ram_ready), .ram_rdata_o(ram_rdata));
	// Free-running clock at 25 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Guard against a hung handshake.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits for ack at falling edges, where registered outputs have settled.
	task automatic wt(input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge sys_clk);
			ok = (cpu_ack === 1'b1);
			if (ext_strobe === 1'b1) xb = ext_out;
		end
		rd = cpu_rdata;
	endtask
	// Request is raised for exactly one take edge, since a held one is taken again.
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input int lim);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_we <= w;
		cpu_req <= 1'b1;
		@(posedge sys_clk);
		cpu_req <= 1'b0;
		wt(lim);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 12);
		chk(16'(ok), 16'h0001);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 40);
		chk(16'(rd), 16'(e));
	endtask
	task automatic setp(input logic [15:0] p);
		wr(16'h7FE3, p[15:8]);
		wr(16'h7FE4, p[7:0]);
	endtask
	task automatic ptrc(input logic [15:0] e);
		rdc(16'h7FE3, e[15:8]);
		rdc(16'h7FE4, e[7:0]);
	endtask
	task automatic endt(input string s);
		$display("test %0s done", s);
	endtask
	// Main sequence: reset check and rows first, then the awkward cases.
	initial begin
		reset_n = 1'b0;
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		cpu_addr = 16'h0000;
		cpu_wdata = 8'h00;
		stall = 1'b0;
		ext_in = 8'h3C;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		ptrc(16'h0000);
		endt("reset");
		foreach (rows[i]) begin
			acc(rows[i].w, rows[i].a, rows[i].d, 12);
			if (!rows[i].w) chk(16'(rd), 16'(rows[i].e));
		end
		endt("registers");
		setp(16'h00FE);
		for (int i = 0; i < 3; i++) wr(16'h7FE5, 8'(8'hA0 + i));
		ptrc(16'h0101);
		setp(16'h00FE);
		for (int i = 0; i < 3; i++) rdc(16'h7FE5, 8'(8'hA0 + i));
		endt("carry");
		stall <= 1'b1;
		setp(16'h0040);
		n = 0;
		do begin
			acc(1'b1, 16'h7FE5, 8'(8'h10 + n), 8);
			n++;
		end while (ok && n < 9);
		chk(16'(ok), 16'h0000);
		chk(16'(n > 4), 16'h0001);
		stall <= 1'b0;
		wt(40);
		chk(16'(ok), 16'h0001);
		setp(16'h0040);
		for (int i = 0; i < n; i++) rdc(16'h7FE5, 8'(8'h10 + i));
		endt("buffer");
		setp(16'h2000);
		wr(16'h7FE5, 8'h77);
		rdc(16'h7FE5, 8'h00);
		ptrc(16'h2002);
		endt("window");
		wr(16'h7FE2, 8'h40);
		chk(16'(fbe), 16'h0001);
		setp(16'h0010);
		wr(16'h7FE5, 8'h00);
		setp(16'h0010);
		xb = 8'h00;
		acc(1'b0, 16'h7FE5, 8'h00, 40);
		chk(16'(xb), 16'h003C);
		endt("fast");
		@(posedge sys_clk);
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		ptrc(16'h0000);
		chk(16'(fbe), 16'h0000);
		endt("second reset");
		finish_test();
	end
endmodule
bind aip_top aip_top_monitor #(.RAM_BASE(RAM_BASE), .RAM_SIZE(RAM_SIZE)) aip_top_monitor_inst (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
	.cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_busy_o(cpu_busy_o),
	.cpu_ack_o(cpu_ack_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
	.ram_we_o(ram_we_o), .ram_re_o(ram_re_o), .ram_ready_i(ram_ready_i),
	.ext_strobe_o(ext_strobe_o), .fast_bulk_enable_o(fast_bulk_enable_o));
`default_nettype wire
